/* File: smsb_regs.vh */
// Purpose: constants for the serial mode select and bridge block
// Assumes: 40 MHz core clock
// Notes:   pin indices count from the lowest of the eight shared pins
//
// Behaviour
// - Pins become serial only with alternate byte FFh and code 000/010/011.
// - Code 000 gives hardware control; 010/011 use the mode pin.
// - Alternate byte 00h gives plain GPIO; mixed values disable everything.
// - Hardware control link: 9600 baud, 8N1, no flow control.
// - Hardware control lets the partner inspect EEPROM, I2C and GPIO state.
// - Emulation takes frame settings from config; CTS only when enabled, RTS always.
// - Entering emulation does system-open then TCP open, active or passive.
// - Active open connects to destination and port, reconnecting on close.
// - Passive open listens on the local port and accepts a peer.
// - Forward received data at 536 bytes or about 100 idle characters.
// - Network payloads are checked and stripped of headers before sending.
// - DTR# low after emulation init; high in hardware control.
// - RTS# low when receive space exists in emulation; low in control.
// - DSR# is ignored in every mode.

`ifndef SMSB_REGS_VH
`define SMSB_REGS_VH

`define SMSB_ALT_SERIAL 8'hFF
`define SMSB_ALT_GPIO   8'h00
`define SMSB_CFG_HWC    3'h0
`define SMSB_CFG_ACTIVE 3'h2
`define SMSB_CFG_PASSIV 3'h3

`define SMSB_CLK_HZ     40000000
`define SMSB_HWC_BAUD   9600
`define SMSB_PKT_BYTES  10'h218
`define SMSB_IDLE_CHARS 100
`define SMSB_CHAR_BITS  10
`define SMSB_GUARD_MS   100

`define SMSB_PIN_RXD  0
`define SMSB_PIN_TXD  1
`define SMSB_PIN_MODE 2
`define SMSB_PIN_CTS  4
`define SMSB_PIN_DSR  5
`define SMSB_PIN_RTS  6
`define SMSB_PIN_DTR  7

`endif

/* File: smsb_bridge.v */
// Purpose: serial pin mux, mode select and serial/network byte bridge
// Assumes: network stack outside handles TCP; pins pass a 2-stage sync
// Notes:   FIFO of eight bytes sits between serial receive and network
`timescale 1ns/1ps
`include "smsb_regs.vh"

module smsb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] s_data,
  input  wire             s_valid,
  output wire             s_ready,
  output reg  [WIDTH-1:0] m_data,
  output reg              m_valid,
  input  wire             m_ready,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign s_ready = (cnt_q != DEPTH[AW:0]);
  assign push    = s_valid & s_ready;
  // Output stage refills whenever it is free or being taken
  assign pop     = (cnt_q != {(AW+1){1'b0}}) & (~m_valid | m_ready);
  assign empty   = (cnt_q == {(AW+1){1'b0}}) & ~m_valid;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= s_data;
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      wr_q    <= {AW{1'b0}};
      rd_q    <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      m_valid <= 1'b0;
      m_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        rd_q    <= rd_q + {{(AW-1){1'b0}}, 1'b1};
        m_data  <= mem[rd_q];
        m_valid <= 1'b1;
      end
      else if (m_ready)
        m_valid <= 1'b0;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module smsb_bridge #(
  parameter HWC_DIV  = (`SMSB_CLK_HZ + `SMSB_HWC_BAUD / 2) / `SMSB_HWC_BAUD,
  parameter HDR_LEN  = 8,
  parameter FIFO_DEP = 8
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  pin_i,
  output reg  [7:0]  pin_o_q,
  output reg  [7:0]  pin_oe_q,
  input  wire [7:0]  gpio_out,
  input  wire [7:0]  gpio_oe,
  output reg  [7:0]  gpio_in_q,
  input  wire [7:0]  pin_alternate_select,
  input  wire [2:0]  serial_config_code,
  input  wire [15:0] frame_baud_div,
  input  wire        frame_flow_en,
  input  wire [15:0] system_open_params,
  input  wire [15:0] dest_ip_high,
  input  wire [15:0] dest_ip_low,
  input  wire [15:0] local_port,
  output reg         mode_gpio_q,
  output reg         mode_hwc_q,
  output reg         mode_emu_q,
  output reg  [7:0]  hwc_rx_data_q,
  output reg         hwc_rx_valid_q,
  input  wire [7:0]  hwc_tx_data,
  input  wire        hwc_tx_valid,
  output reg         hwc_tx_ready_q,
  output reg         sys_open_req_q,
  output reg  [15:0] sys_open_arg_q,
  input  wire        sys_open_done,
  output reg         tcp_open_req_q,
  output reg         tcp_open_active_q,
  output reg  [31:0] tcp_dest_ip_q,
  output reg  [15:0] tcp_port_q,
  input  wire        conn_up,
  input  wire        conn_closed,
  output wire [7:0]  net_tx_data,
  output wire        net_tx_valid,
  input  wire        net_tx_ready,
  output reg         net_tx_flush_q,
  input  wire [7:0]  net_rx_data,
  input  wire        net_rx_valid,
  input  wire        net_rx_last,
  input  wire        net_rx_err,
  output reg         net_rx_ready_q
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_SOPEN = 2'h1;
  localparam ST_TOPEN = 2'h2;
  localparam ST_UP    = 2'h3;
  localparam IDLE_INT = `SMSB_IDLE_CHARS * `SMSB_CHAR_BITS;
  localparam [9:0] IDLE_BITS = IDLE_INT[9:0];
  // RXD resets to its idle level so no false start follows reset
  localparam [7:0] SYNC_IDLE = 8'h01 << `SMSB_PIN_RXD;
  localparam [15:0] HWC_DIV16 = HWC_DIV[15:0];
  localparam [7:0] HDR8 = HDR_LEN[7:0];

  reg  [7:0]  sync1_q;
  reg  [7:0]  pin_s_q;
  reg  [1:0]  st_q;
  reg         init_done_q;
  reg  [15:0] tx_cnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [9:0]  tx_sh_q;
  reg         tx_busy_q;
  reg  [7:0]  hold_q;
  reg         hold_v_q;
  reg  [7:0]  hdr_cnt_q;
  reg         drop_q;
  reg  [15:0] rx_cnt_q;
  reg  [3:0]  rx_bit_q;
  reg  [7:0]  rx_sh_q;
  reg         rx_busy_q;
  reg         rx_byte_q;
  reg  [15:0] idle_cnt_q;
  reg  [9:0]  idle_bits_q;
  reg  [9:0]  pkt_cnt_q;
  reg         flush_pend_q;
  wire        alt_ser;
  wire        cfg_ok;
  wire        ser_en;
  wire        mode_pin;
  wire        rxd;
  wire        cts_hi;
  wire [15:0] div;
  wire        tx_stall;
  wire        net_take;
  wire        hwc_take;
  wire        net_keep;
  wire        tx_load;
  wire        hold_next;
  wire        fifo_ready;
  wire        fifo_empty;
  wire        fifo_push;

  // Two flops on every pin before any logic looks at it
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q   <= SYNC_IDLE;
      pin_s_q   <= SYNC_IDLE;
      gpio_in_q <= 8'h00;
    end
    else
    begin
      sync1_q   <= pin_i;
      pin_s_q   <= sync1_q;
      gpio_in_q <= pin_s_q;
    end
  end

  assign mode_pin = pin_s_q[`SMSB_PIN_MODE];
  assign rxd      = pin_s_q[`SMSB_PIN_RXD];
  assign cts_hi   = pin_s_q[`SMSB_PIN_CTS];
  // DSR# pin is never read, in any mode
  assign alt_ser  = (pin_alternate_select == `SMSB_ALT_SERIAL);
  assign cfg_ok   = (serial_config_code == `SMSB_CFG_HWC) |
                    (serial_config_code == `SMSB_CFG_ACTIVE) |
                    (serial_config_code == `SMSB_CFG_PASSIV);
  assign ser_en   = alt_ser & cfg_ok;

  always @(posedge clk)
  begin
    if (rst)
    begin
      mode_gpio_q <= 1'b0;
      mode_hwc_q  <= 1'b0;
      mode_emu_q  <= 1'b0;
    end
    else
    begin
      mode_gpio_q <= (pin_alternate_select == `SMSB_ALT_GPIO);
      mode_hwc_q  <= ser_en &
        ((serial_config_code == `SMSB_CFG_HWC) | mode_pin);
      mode_emu_q  <= ser_en & ~mode_pin &
        (serial_config_code != `SMSB_CFG_HWC);
    end
  end

  // Fixed 9600 baud in control mode, programmed divider otherwise
  assign div = mode_hwc_q ? HWC_DIV16 : frame_baud_div;

  // Connection bring-up
  always @(posedge clk)
  begin
    if (rst)
    begin
      st_q              <= ST_IDLE;
      init_done_q       <= 1'b0;
      sys_open_req_q    <= 1'b0;
      sys_open_arg_q    <= 16'h0000;
      tcp_open_req_q    <= 1'b0;
      tcp_open_active_q <= 1'b0;
      tcp_dest_ip_q     <= 32'h00000000;
      tcp_port_q        <= 16'h0000;
    end
    else
    begin
      sys_open_req_q <= 1'b0;
      tcp_open_req_q <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          init_done_q <= 1'b0;
          if (mode_emu_q)
          begin
            st_q           <= ST_SOPEN;
            sys_open_req_q <= 1'b1;
            sys_open_arg_q <= system_open_params;
          end
        end
        ST_SOPEN:
          if (sys_open_done)
          begin
            st_q              <= ST_TOPEN;
            init_done_q       <= 1'b1;
            tcp_open_req_q    <= 1'b1;
            tcp_open_active_q <=
              (serial_config_code == `SMSB_CFG_ACTIVE);
            tcp_dest_ip_q     <= {dest_ip_high, dest_ip_low};
            tcp_port_q        <= local_port;
          end
        ST_TOPEN:
          if (conn_up)
            st_q <= ST_UP;
        ST_UP:
          if (conn_closed)
          begin
            // Active side redials, passive side listens again
            st_q           <= ST_TOPEN;
            tcp_open_req_q <= 1'b1;
          end
        default:
          st_q <= ST_IDLE;
      endcase
      if (!mode_emu_q)
        st_q <= ST_IDLE;
    end
  end

  // Transmit path: one holding byte fed by either source
  assign tx_stall  = mode_emu_q & frame_flow_en & cts_hi;
  assign tx_load   = hold_v_q & ~tx_busy_q & ~tx_stall;
  assign hwc_take  = hwc_tx_valid & hwc_tx_ready_q;
  assign net_take  = net_rx_valid & net_rx_ready_q;
  assign net_keep  = net_take & (hdr_cnt_q >= HDR8) & ~drop_q &
                     ~(hdr_cnt_q == 8'h00 & net_rx_err);
  assign hold_next = (hold_v_q & ~tx_load) | hwc_take | net_keep;

  always @(posedge clk)
  begin
    if (rst)
    begin
      hold_q         <= 8'h00;
      hold_v_q       <= 1'b0;
      hwc_tx_ready_q <= 1'b0;
      net_rx_ready_q <= 1'b0;
      hdr_cnt_q      <= 8'h00;
      drop_q         <= 1'b0;
    end
    else
    begin
      hold_v_q       <= hold_next;
      hwc_tx_ready_q <= mode_hwc_q & ~hold_next;
      net_rx_ready_q <= mode_emu_q & ~hold_next;
      if (hwc_take)
        hold_q <= hwc_tx_data;
      else if (net_keep)
        hold_q <= net_rx_data;
      if (net_take)
      begin
        // A bad payload, flagged on its first byte, is dropped whole
        if (hdr_cnt_q == 8'h00)
          drop_q <= net_rx_err;
        if (hdr_cnt_q != 8'hFF)
          hdr_cnt_q <= hdr_cnt_q + 8'h01;
        if (net_rx_last)
        begin
          hdr_cnt_q <= 8'h00;
          drop_q    <= 1'b0;
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
      tx_busy_q <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_sh_q   <= {1'b1, hold_q, 1'b0};
      tx_busy_q <= 1'b1;
      tx_bit_q  <= 4'h0;
      tx_cnt_q  <= div - 16'h0001;
    end
    else if (tx_busy_q)
    begin
      if (tx_cnt_q == 16'h0000)
      begin
        tx_cnt_q <= div - 16'h0001;
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == 4'h9)
          tx_busy_q <= 1'b0;
      end
      else
        tx_cnt_q <= tx_cnt_q - 16'h0001;
    end
  end

  // Receive path: sample mid-bit, stop bit must be high
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx_cnt_q       <= 16'h0000;
      rx_bit_q       <= 4'h0;
      rx_sh_q        <= 8'h00;
      rx_busy_q      <= 1'b0;
      rx_byte_q      <= 1'b0;
      hwc_rx_data_q  <= 8'h00;
      hwc_rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_byte_q      <= 1'b0;
      hwc_rx_valid_q <= 1'b0;
      if (!rx_busy_q)
      begin
        if (!rxd && (mode_hwc_q || mode_emu_q))
        begin
          rx_busy_q <= 1'b1;
          rx_bit_q  <= 4'h0;
          rx_cnt_q  <= {1'b0, div[15:1]};
        end
      end
      else if (rx_cnt_q != 16'h0000)
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      else
      begin
        rx_cnt_q <= div - 16'h0001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rxd)
          rx_busy_q <= 1'b0;
        else if (rx_bit_q == 4'h9)
        begin
          rx_busy_q <= 1'b0;
          if (rxd)
          begin
            rx_byte_q      <= mode_emu_q;
            hwc_rx_valid_q <= mode_hwc_q;
            hwc_rx_data_q  <= rx_sh_q;
          end
        end
        else if (rx_bit_q != 4'h0)
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
      end
    end
  end

  // Bytes arriving with the FIFO full are lost; RTS# warns the sender
  assign fifo_push = rx_byte_q & fifo_ready;

  smsb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEP),
    .AW    (3)
  ) u_fifo (
    .clk     (clk),
    .rst     (rst),
    .s_data  (rx_sh_q),
    .s_valid (rx_byte_q),
    .s_ready (fifo_ready),
    .m_data  (net_tx_data),
    .m_valid (net_tx_valid),
    .m_ready (net_tx_ready),
    .empty   (fifo_empty)
  );

  // Packet boundary: full segment or a quiet line
  always @(posedge clk)
  begin
    if (rst)
    begin
      idle_cnt_q     <= 16'h0000;
      idle_bits_q    <= 10'h000;
      pkt_cnt_q      <= 10'h000;
      flush_pend_q   <= 1'b0;
      net_tx_flush_q <= 1'b0;
    end
    else
    begin
      net_tx_flush_q <= 1'b0;
      if (fifo_push || rx_busy_q || !mode_emu_q)
      begin
        idle_cnt_q  <= 16'h0000;
        idle_bits_q <= 10'h000;
      end
      else if (idle_cnt_q >= div - 16'h0001)
      begin
        idle_cnt_q <= 16'h0000;
        if (idle_bits_q != IDLE_BITS)
          idle_bits_q <= idle_bits_q + 10'h001;
      end
      else
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      // Wait until every counted byte has left the FIFO
      if (flush_pend_q && fifo_empty)
      begin
        flush_pend_q   <= 1'b0;
        net_tx_flush_q <= 1'b1;
      end
      // A boundary in the same cycle wins, so its request stays pending
      if (fifo_push)
      begin
        if (pkt_cnt_q + 10'h001 == `SMSB_PKT_BYTES)
        begin
          pkt_cnt_q    <= 10'h000;
          flush_pend_q <= 1'b1;
        end
        else
          pkt_cnt_q <= pkt_cnt_q + 10'h001;
      end
      else if (idle_bits_q == IDLE_BITS && pkt_cnt_q != 10'h000)
      begin
        pkt_cnt_q    <= 10'h000;
        flush_pend_q <= 1'b1;
      end
    end
  end

  // Pin drive per mode
  always @(posedge clk)
  begin
    if (rst)
    begin
      pin_o_q  <= 8'h00;
      pin_oe_q <= 8'h00;
    end
    else if (mode_gpio_q)
    begin
      pin_o_q  <= gpio_out;
      pin_oe_q <= gpio_oe;
    end
    else if (mode_hwc_q || mode_emu_q)
    begin
      pin_o_q <= 8'h00;
      pin_o_q[`SMSB_PIN_TXD] <= tx_sh_q[0];
      pin_o_q[`SMSB_PIN_DTR] <= ~(mode_emu_q & init_done_q);
      pin_o_q[`SMSB_PIN_RTS] <= mode_emu_q & ~fifo_ready;
      pin_oe_q <= 8'h00;
      pin_oe_q[`SMSB_PIN_TXD] <= 1'b1;
      pin_oe_q[`SMSB_PIN_DTR] <= 1'b1;
      pin_oe_q[`SMSB_PIN_RTS] <= 1'b1;
    end
    else
    begin
      pin_o_q  <= 8'h00;
      pin_oe_q <= 8'h00;
    end
  end
endmodule

/* File: smsb_partner.sv */
// Purpose: serial device beyond the shared pins
// Assumes: DIV clocks per bit, 8N1
// Notes:   tasks are driven from the bench
`timescale 1ns/1ps
module smsb_partner #(
  parameter DIV = 16
) (
  input  wire clk,
  input  wire txd,
  input  wire stop_rx,
  output reg  rxd,
  output wire cts_n
);
  // Bench raises it well before its buffer fills
  assign cts_n = stop_rx;
  initial rxd = 1'b1;
  task send(input [7:0] b);
    integer k;
    begin
      rxd <= 1'b0;
      repeat (DIV) @(posedge clk);
      for (k = 0; k < 8; k = k + 1)
      begin
        rxd <= b[k];
        repeat (DIV) @(posedge clk);
      end
      rxd <= 1'b1;
      repeat (DIV) @(posedge clk);
    end
  endtask
  task recv(output [7:0] b, output ok);
    integer k;
    begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge clk);
      ok = !txd;
      for (k = 0; k < 8; k = k + 1)
      begin
        repeat (DIV) @(posedge clk);
        b[k] = txd;
      end
      repeat (DIV) @(posedge clk);
      ok = ok & txd;
    end
  endtask
endmodule

/* File: smsb_bridge_assertions.sv */
// Purpose: port checks for smsb_bridge
// Assumes: sync reset, mode flags one edge after inputs
// Notes:   bit length checked in control mode only
`timescale 1ns/1ps
module smsb_bridge_assertions #(
  parameter HWC_DIV = 16
) (
  input wire        clk,
  input wire        rst,
  input wire [7:0]  pin_o_q,
  input wire [7:0]  pin_oe_q,
  input wire [7:0]  pin_alternate_select,
  input wire [2:0]  serial_config_code,
  input wire [15:0] system_open_params,
  input wire [15:0] dest_ip_high,
  input wire [15:0] dest_ip_low,
  input wire [15:0] local_port,
  input wire        mode_gpio_q,
  input wire        mode_hwc_q,
  input wire        mode_emu_q,
  input wire        hwc_rx_valid_q,
  input wire        sys_open_req_q,
  input wire [15:0] sys_open_arg_q,
  input wire        tcp_open_req_q,
  input wire        tcp_open_active_q,
  input wire [31:0] tcp_dest_ip_q,
  input wire [15:0] tcp_port_q
);
  wire [7:0]  alt = pin_alternate_select;
  wire        mix = alt != 8'hFF && alt != 8'h00;
  wire        h0 = alt == 8'hFF && serial_config_code == 3'h0;
  reg  [15:0] low_q;
  always @(posedge clk)
    if (rst || pin_o_q[1] || !pin_oe_q[1] || !mode_hwc_q)
      low_q <= 16'h0000;
    else
      low_q <= low_q + 16'h0001;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  mode_one_hot_a: assert property (
    $onehot0({mode_gpio_q, mode_hwc_q, mode_emu_q}))
    else $error("two modes at once");
  mixed_off_a: assert property (mix && $past(mix) |->
    !mode_gpio_q && !mode_hwc_q && !mode_emu_q)
    else $error("mode active with mixed alternate byte");
  gpio_mode_a: assert property (alt == 8'h00 &&
    $past(alt) == 8'h00 && !$past(rst) |-> mode_gpio_q)
    else $error("gpio mode missing");
  hwc_code0_a: assert property (
    h0 && $past(h0) && !$past(rst) |-> mode_hwc_q)
    else $error("control mode missing for code 0");
  emu_code_a: assert property (mode_emu_q |->
    $past(alt) == 8'hFF && $past(serial_config_code) inside {3'h2, 3'h3})
    else $error("emulation without its codes");
  rx_pulse_a: assert property (
    hwc_rx_valid_q |-> mode_hwc_q ##1 !hwc_rx_valid_q)
    else $error("receive pulse wrong");
  open_arg_a: assert property (
    sys_open_req_q |-> sys_open_arg_q == system_open_params)
    else $error("system open argument wrong");
  tcp_kind_a: assert property (tcp_open_req_q |->
    tcp_open_active_q == (serial_config_code == 3'h2))
    else $error("open kind wrong");
  tcp_dest_a: assert property (tcp_open_req_q |->
    tcp_port_q == local_port && (!tcp_open_active_q ||
    tcp_dest_ip_q == {dest_ip_high, dest_ip_low}))
    else $error("open target wrong");
  hwc_lines_a: assert property (mode_hwc_q [*4] |->
    pin_o_q[7] && pin_oe_q[7] && !pin_o_q[6] && pin_oe_q[6])
    else $error("handshake lines wrong in control mode");
  // Short runs skipped: idle appears a little after mode entry
  tx_bit_len_a: assert property ($rose(pin_o_q[1]) &&
    low_q > 16'h0003 |-> low_q % HWC_DIV == 0)
    else $error("transmit bit length wrong");
  cover property (mode_emu_q && tcp_open_req_q);
  cover property (hwc_rx_valid_q);
  cover property (mix ##1 mix);
endmodule
bind smsb_bridge smsb_bridge_assertions #(.HWC_DIV(HWC_DIV))
  smsb_bridge_assertions_inst (.*);

/* File: smsb_bridge_test.sv */
// Purpose: self-checking bench for smsb_bridge
// Assumes: bit period cut to 16 clocks, header of 8 bytes
// Notes:   536-byte flush too long to run; idle flush is
`timescale 1ns/1ps
module smsb_bridge_test;
  localparam DIV = 16;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [7:0]  gpio_out = 8'h00, gpio_oe = 8'h00;
  reg  [7:0]  pin_alternate_select = 8'h00;
  reg  [2:0]  serial_config_code = 3'h0;
  reg  [15:0] frame_baud_div = 16'h0010;
  reg         frame_flow_en = 1'b0;
  reg  [15:0] system_open_params = 16'h0000, local_port = 16'h0000;
  reg  [15:0] dest_ip_high = 16'h0000, dest_ip_low = 16'h0000;
  reg  [7:0]  hwc_tx_data = 8'h00, net_rx_data = 8'h00;
  reg         hwc_tx_valid = 1'b0, net_tx_ready = 1'b0;
  reg         sys_open_done = 1'b0, conn_up = 1'b0, conn_closed = 1'b0;
  reg         net_rx_valid = 1'b0, net_rx_last = 1'b0, net_rx_err = 1'b0;
  reg         mode_pin = 1'b0, dsr_n = 1'b1, stop_rx = 1'b0;
  reg         m, ok;
  reg  [31:0] r;
  reg  [7:0]  a, b, got;
  reg  [2:0]  c;
  reg  [7:0]  sent [0:9];
  reg  [7:0]  dat [0:2];
  integer     i, j, t0, n_mismatch = 0, n_tests = 0, cyc = 0, n_start = 0;
  wire        rxd, cts_n;
  wire [7:0]  pin_i, pin_o_q, pin_oe_q, gpio_in_q, hwc_rx_data_q;
  wire        mode_gpio_q, mode_hwc_q, mode_emu_q, hwc_rx_valid_q;
  wire        hwc_tx_ready_q, sys_open_req_q, tcp_open_req_q;
  wire        tcp_open_active_q, net_tx_valid, net_tx_flush_q;
  wire        net_rx_ready_q;
  wire [15:0] sys_open_arg_q, tcp_port_q;
  wire [31:0] tcp_dest_ip_q;
  wire [7:0]  net_tx_data;
  // Undriven pins read high through pull-ups
  wire [7:0]  lvl = (pin_o_q & pin_oe_q) | ~pin_oe_q;
  assign pin_i = {lvl[7:6], dsr_n, cts_n, lvl[3], mode_pin, lvl[1], rxd};
  smsb_bridge #(.HWC_DIV(DIV)) smsb_bridge_inst (.*);
  smsb_partner #(.DIV(DIV)) smsb_partner_inst (.clk(clk), .txd(lvl[1]),
    .stop_rx(stop_rx), .rxd(rxd), .cts_n(cts_n));
  always #12.5 clk = ~clk;
  always @(negedge lvl[1]) n_start <= n_start + 1;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  function [2:0] exp_mode(input [7:0] a, input [2:0] c, input m);
    begin
      exp_mode = 3'h0;
      if (a == 8'h00)
        exp_mode = 3'h4;
      else if (a == 8'hFF && c == 3'h0)
        exp_mode = 3'h2;
      else if (a == 8'hFF && (c == 3'h2 || c == 3'h3))
        exp_mode = m ? 3'h2 : 3'h1;
    end
  endfunction
  task setm(input [7:0] a, input [2:0] c, input m, input integer n);
    begin
      r = $urandom;
      pin_alternate_select <= a;
      serial_config_code <= c;
      mode_pin <= m;
      dsr_n <= r[0];
      repeat (n) @(posedge clk);
    end
  endtask
  task pulse(input [2:0] w);
    begin
      {sys_open_done, conn_up, conn_closed} <= w;
      @(posedge clk);
      {sys_open_done, conn_up, conn_closed} <= 3'h0;
    end
  endtask
  task npush(input [7:0] d, input l, input e);
    begin
      net_rx_data <= d;
      net_rx_last <= l;
      net_rx_err <= e;
      net_rx_valid <= 1'b1;
      @(posedge clk iff net_rx_ready_q);
    end
  endtask
  task pay(input integer n, input e);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1)
      begin
        r = $urandom;
        npush(k < 8 ? r[7:0] : dat[k - 8], k == n - 1, e && k == 0);
      end
      net_rx_valid <= 1'b0;
    end
  endtask
  initial
  begin
    r = $urandom(26);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (i = 0; i < 18; i = i + 1)
    begin
      r = $urandom;
      a = (i < 6) ? 8'hFF : (i < 12) ? 8'h00 : 8'h01 + r[7:0] % 8'hFE;
      c = (i % 3 == 0) ? 3'h0 : (i % 3 == 1) ? 3'h2 : 3'h3;
      m = ((i / 3) % 2) == 1;
      gpio_out <= r[15:8];
      gpio_oe <= r[23:16];
      setm(a, c, m, 64);
      chk("mode", {mode_gpio_q, mode_hwc_q, mode_emu_q}, exp_mode(a, c, m));
      if (a == 8'h00)
      begin
        chk("gpio_oe", pin_oe_q, gpio_oe);
        chk("gpio_o", pin_o_q & gpio_oe, gpio_out & gpio_oe);
        chk("gpio_in", gpio_in_q, pin_i);
      end
      else if (a != 8'hFF)
        chk("off_oe", pin_oe_q, 8'h00);
    end
    setm(8'hFF, 3'h0, 1'b1, 64);
    chk("dtr_hwc", lvl[7], 1'b1);
    chk("rts_hwc", lvl[6], 1'b0);
    for (i = 0; i < 3; i = i + 1)
    begin
      r = $urandom;
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[7:0];
      fork
        smsb_partner_inst.send(b);
        begin
          @(negedge clk iff hwc_rx_valid_q);
          got = hwc_rx_data_q;
        end
      join
      chk("hwc_rx", got, b);
    end
    // No flow control here, so a raised stall must not matter
    stop_rx <= 1'b1;
    for (i = 0; i < 2; i = i + 1)
    begin
      r = $urandom;
      fork
        smsb_partner_inst.recv(got, ok);
        begin
          hwc_tx_data <= r[7:0];
          hwc_tx_valid <= 1'b1;
          @(posedge clk iff hwc_tx_ready_q);
          hwc_tx_valid <= 1'b0;
        end
      join
      chk("hwc_tx", {ok, got}, {1'b1, r[7:0]});
    end
    stop_rx <= 1'b0;
    r = $urandom;
    system_open_params <= r[15:0];
    dest_ip_high <= r[31:16];
    dest_ip_low <= r[15:0] ^ 16'h5A5A;
    local_port <= r[31:16] ^ 16'h00FF;
    for (i = 0; i < 2; i = i + 1)
    begin
      setm(8'hFF, 3'h0, 1'b0, 4);
      setm(8'hFF, i ? 3'h3 : 3'h2, 1'b0, 0);
      @(negedge clk iff sys_open_req_q);
      chk("sys_arg", sys_open_arg_q, system_open_params);
      @(posedge clk);
      pulse(3'h4);
      @(negedge clk iff tcp_open_req_q);
      chk("active", tcp_open_active_q, i == 0);
      chk("port", tcp_port_q, local_port);
      if (i == 0)
        chk("ip", tcp_dest_ip_q, {dest_ip_high, dest_ip_low});
      @(posedge clk);
      pulse(3'h2);
      repeat (4) @(posedge clk);
      chk("dtr_emu", lvl[7], 1'b0);
      if (i == 0)
      begin
        pulse(3'h1);
        @(negedge clk iff tcp_open_req_q);
        chk("reopen", tcp_open_active_q, 1'b1);
        @(posedge clk);
        pulse(3'h2);
      end
    end
    for (i = 0; i < 10; i = i + 1)
    begin
      r = $urandom;
      sent[i] = r[7:0];
      smsb_partner_inst.send(r[7:0]);
    end
    t0 = cyc;
    repeat (40) @(posedge clk);
    chk("rts_full", lvl[6], 1'b1);
    net_tx_ready <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
    begin
      @(negedge clk iff net_tx_valid);
      chk("net_tx", net_tx_data, sent[i]);
    end
    chk("rts_room", lvl[6], 1'b0);
    @(negedge clk iff net_tx_flush_q);
    chk("idle_gap", cyc - t0 >= 15000, 1'b1);
    for (j = 0; j < 3; j = j + 1)
    begin
      r = $urandom;
      dat[j] = r[7:0];
    end
    fork
      pay(11, 1'b0);
      for (j = 0; j < 3; j = j + 1)
      begin
        smsb_partner_inst.recv(got, ok);
        chk("net_rx", {ok, got}, {1'b1, dat[j]});
      end
    join
    j = n_start;
    pay(10, 1'b1);
    repeat (400) @(posedge clk);
    chk("err_drop", n_start, j);
    frame_flow_en <= 1'b1;
    stop_rx <= 1'b1;
    j = n_start;
    pay(9, 1'b0);
    repeat (400) @(posedge clk);
    chk("cts_hold", n_start, j);
    fork
      smsb_partner_inst.recv(got, ok);
      begin
        @(posedge clk);
        stop_rx <= 1'b0;
      end
    join
    chk("cts_go", {ok, got}, {1'b1, dat[0]});
    print_verdict;
  end
endmodule
